// >>> src/axis_setup.sv
// Axis setup, homing sequencer, encoder null clear, freewheel and error flags.
// Assumes a motion core that reports velocity, ramp phase and position, and
// switch, encoder and load inputs synchronous to clock_i.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module axis_setup #(
	parameter int FREEWHEEL_TICK = axis_setup_pkg::FREEWHEEL_TICK_CYCLES
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic enable_i,
	input wire logic [9:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [31:0] rdata_o,
	input wire logic [31:0] position_i,
	input wire logic [10:0] velocity_i,
	input wire logic ramping_i,
	input wire logic [9:0] load_i,
	input wire logic [31:0] encoder_i,
	input wire logic null_channel_i,
	input wire axis_setup_pkg::switch_set_t switches_i,
	output axis_setup_pkg::motor_drive_t drive_o,
	output logic position_zero_o,
	output logic encoder_clear_o,
	output logic random_off_time_o,
	output logic homing_busy_o
);
	// Refuse a tick that the freewheel counter cannot count
	if (FREEWHEEL_TICK < 1) begin : g_bad_tick
		$error("FREEWHEEL_TICK must be at least one cycle");
	end

	typedef enum logic [2:0] {
		HS_IDLE, HS_FIRST, HS_ROUGH, HS_BACKOFF, HS_FINE, HS_ZERO
	} homing_state_t;

	// Registers
	logic [7:0] slow_run_current_q, run_current_q, ramp_boost_current_q, homing_mode_q;
	logic random_off_time_select_q;
	logic [10:0] rough_speed_q, fine_speed_q, slow_threshold_q, stall_speed_q;
	logic [31:0] end_switch_span_q, pre_zero_position_q, max_deviation_q, span_start_q;
	logic [4:0] encoder_null_control_q;
	logic [15:0] freewheel_delay_q, fw_units_q;
	logic [1:0] sticky_error_flags_q;
	logic [31:0] rdata_q, fw_tick_q;
	homing_state_t hs_q;
	logic moving_q, dir_q, null_armed_q, null_prev_q, powered_q, zero_q, enc_clr_q, busy_q;
	axis_setup_pkg::motor_drive_t drive_q;

	// Address decode: index in bits 9:2
	wire [7:0] idx = addr_i[9:2];
	wire wr = write_i & enable_i;
	wire rd = read_i & enable_i;
	wire wr_cmd = wr && idx == axis_setup_pkg::IDX_COMMAND;
	wire cmd_home = wr_cmd & wdata_i[axis_setup_pkg::CMD_HOMING_BIT];
	wire cmd_move = wr_cmd & wdata_i[axis_setup_pkg::CMD_MOVE_BIT];
	wire cmd_stop = wr_cmd & wdata_i[axis_setup_pkg::CMD_STOP_BIT];
	wire motion_cmd = cmd_home | cmd_move;

	// Homing mode decode; base value in low six bits
	wire [5:0] base_mode = homing_mode_q[5:0];
	wire invert_home = homing_mode_q[axis_setup_pkg::MODE_INVERT_HOME_BIT];
	wire use_right = homing_mode_q[axis_setup_pkg::MODE_RIGHT_REF_BIT];
	wire home_level = switches_i.home ^ invert_home;
	wire ref_switch = use_right ? switches_i.right_stop : switches_i.left_stop;
	wire stop_mode = base_mode >= 6'h01 && base_mode <= 6'h04;
	wire two_sided = base_mode == 6'h03 || base_mode == 6'h04;
	wire right_first = base_mode == 6'h02 || base_mode == 6'h03;
	wire ignore_ends = base_mode == 6'h07 || base_mode == 6'h08;
	// Stop modes head towards the reference; home modes per mode number
	wire rough_dir = stop_mode ? use_right :
		(base_mode == 6'h06 || base_mode == 6'h07);
	wire target_hit = stop_mode ? ref_switch : home_level;
	wire far_stop = (base_mode == 6'h05 && switches_i.left_stop) ||
		(base_mode == 6'h06 && switches_i.right_stop);
	wire first_hit = use_right ? switches_i.left_stop : switches_i.right_stop;

	// Stop conditions
	wire stall_evt = moving_q && velocity_i > stall_speed_q && load_i == 10'h000;
	wire [31:0] dev_raw = position_i - encoder_i;
	wire [31:0] dev_abs = dev_raw[31] ? 32'h0 - dev_raw : dev_raw;
	wire dev_evt = moving_q && max_deviation_q != 32'h0 && dev_abs > max_deviation_q;
	wire halt = stall_evt | dev_evt | cmd_stop;

	// Encoder null channel, polarity and edge
	wire null_act = null_channel_i ~^ encoder_null_control_q[axis_setup_pkg::NULL_POLARITY_BIT];
	wire null_edge = null_act & ~null_prev_q;
	wire null_repeat = encoder_null_control_q[axis_setup_pkg::NULL_REPEAT_BIT];
	wire null_clear = null_edge && encoder_null_control_q[axis_setup_pkg::NULL_CLEAR_EN_BIT] &&
		(null_repeat || null_armed_q);

	// Current selection
	wire [7:0] boost_sel = ramp_boost_current_q == 8'h00 ? run_current_q : ramp_boost_current_q;
	wire [7:0] cur_sel = ramping_i ? boost_sel :
		(velocity_i < slow_threshold_q ? slow_run_current_q : run_current_q);

	// Freewheel
	wire standstill = velocity_i == 11'h000 && !moving_q;
	wire fw_tick = fw_tick_q == 32'(FREEWHEEL_TICK - 1);
	wire fw_expired = freewheel_delay_q != 16'h0000 && fw_units_q >= freewheel_delay_q;

	// Homing speed per phase: one-sided modes leave the switch at rough speed, two-sided
	// modes time the release at fine speed as well, so the edge is met from both sides
	wire fine_phase = hs_q == HS_FINE || (hs_q == HS_BACKOFF && two_sided);
	wire [10:0] spd_sel = fine_phase ? fine_speed_q : rough_speed_q;

	// Read mux
	logic [31:0] rd_mux;
	always_comb begin
		unique case (idx)
			axis_setup_pkg::IDX_SLOW_RUN_CURRENT: rd_mux = {24'h0, slow_run_current_q};
			axis_setup_pkg::IDX_RANDOM_OFF_TIME: rd_mux = {31'h0, random_off_time_select_q};
			axis_setup_pkg::IDX_HOMING_MODE: rd_mux = {24'h0, homing_mode_q};
			axis_setup_pkg::IDX_ROUGH_SPEED: rd_mux = {21'h0, rough_speed_q};
			axis_setup_pkg::IDX_FINE_SPEED: rd_mux = {21'h0, fine_speed_q};
			axis_setup_pkg::IDX_END_SWITCH_SPAN: rd_mux = end_switch_span_q;
			axis_setup_pkg::IDX_PRE_ZERO_POSITION: rd_mux = pre_zero_position_q;
			axis_setup_pkg::IDX_RAMP_BOOST_CURRENT: rd_mux = {24'h0, ramp_boost_current_q};
			axis_setup_pkg::IDX_ENCODER_NULL_CONTROL: rd_mux = {27'h0, encoder_null_control_q};
			axis_setup_pkg::IDX_FREEWHEEL_DELAY: rd_mux = {16'h0, freewheel_delay_q};
			axis_setup_pkg::IDX_LOAD_MEASUREMENT: rd_mux = {22'h0, load_i};
			axis_setup_pkg::IDX_STICKY_ERROR_FLAGS: rd_mux = {30'h0, sticky_error_flags_q};
			axis_setup_pkg::IDX_RUN_CURRENT: rd_mux = {24'h0, run_current_q};
			axis_setup_pkg::IDX_SLOW_THRESHOLD: rd_mux = {21'h0, slow_threshold_q};
			axis_setup_pkg::IDX_STALL_SPEED: rd_mux = {21'h0, stall_speed_q};
			axis_setup_pkg::IDX_MAX_DEVIATION: rd_mux = max_deviation_q;
			axis_setup_pkg::IDX_STATUS: rd_mux = {29'h0, powered_q, moving_q, hs_q != HS_IDLE};
			default: rd_mux = 32'h0;
		endcase
	end

	// Register writes and read data
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			slow_run_current_q <= axis_setup_pkg::RST_CURRENT;
			run_current_q <= axis_setup_pkg::RST_CURRENT;
			ramp_boost_current_q <= axis_setup_pkg::RST_CURRENT;
			random_off_time_select_q <= 1'b0;
			homing_mode_q <= axis_setup_pkg::RST_HOMING_MODE;
			rough_speed_q <= axis_setup_pkg::RST_SPEED;
			fine_speed_q <= axis_setup_pkg::RST_SPEED;
			slow_threshold_q <= axis_setup_pkg::RST_SPEED;
			stall_speed_q <= axis_setup_pkg::RST_SPEED;
			max_deviation_q <= 32'h0;
			encoder_null_control_q <= axis_setup_pkg::RST_NULL_CONTROL;
			freewheel_delay_q <= axis_setup_pkg::RST_FREEWHEEL;
			rdata_q <= 32'h0;
		end else if (enable_i) begin
			rdata_q <= rd ? rd_mux : 32'h0;
			if (wr) begin
				unique case (idx)
					axis_setup_pkg::IDX_SLOW_RUN_CURRENT: slow_run_current_q <= wdata_i[7:0];
					axis_setup_pkg::IDX_RANDOM_OFF_TIME: random_off_time_select_q <= wdata_i[0];
					axis_setup_pkg::IDX_HOMING_MODE: homing_mode_q <= wdata_i[7:0];
					axis_setup_pkg::IDX_ROUGH_SPEED: rough_speed_q <= wdata_i[10:0];
					axis_setup_pkg::IDX_FINE_SPEED: fine_speed_q <= wdata_i[10:0];
					axis_setup_pkg::IDX_RAMP_BOOST_CURRENT: ramp_boost_current_q <= wdata_i[7:0];
					axis_setup_pkg::IDX_ENCODER_NULL_CONTROL: encoder_null_control_q <= wdata_i[4:0];
					axis_setup_pkg::IDX_FREEWHEEL_DELAY: freewheel_delay_q <= wdata_i[15:0];
					axis_setup_pkg::IDX_RUN_CURRENT: run_current_q <= wdata_i[7:0];
					axis_setup_pkg::IDX_SLOW_THRESHOLD: slow_threshold_q <= wdata_i[10:0];
					axis_setup_pkg::IDX_STALL_SPEED: stall_speed_q <= wdata_i[10:0];
					axis_setup_pkg::IDX_MAX_DEVIATION: max_deviation_q <= wdata_i;
					default: ;
				endcase
			end
		end
	end

	// Sticky errors: a new event wins over the clear so none is lost
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sticky_error_flags_q <= 2'b00;
		end else if (enable_i) begin
			sticky_error_flags_q <= (((rd && idx == axis_setup_pkg::IDX_STICKY_ERROR_FLAGS) ||
				motion_cmd) ? 2'b00 : sticky_error_flags_q) | {dev_evt, stall_evt};
		end
	end

	// Homing sequencer: rough approach, back off, fine edge search, zero
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hs_q <= HS_IDLE;
			dir_q <= 1'b0;
			moving_q <= 1'b0;
			zero_q <= 1'b0;
			span_start_q <= 32'h0;
			end_switch_span_q <= 32'h0;
			pre_zero_position_q <= 32'h0;
		end else if (enable_i) begin
			zero_q <= 1'b0;
			if (halt) begin
				hs_q <= HS_IDLE;
				moving_q <= 1'b0;
			end else if (cmd_move) begin
				moving_q <= 1'b1;
				dir_q <= wdata_i[31];
			end else begin
				unique case (hs_q)
					HS_IDLE: if (cmd_home) begin
						moving_q <= 1'b1;
						hs_q <= right_first ? HS_FIRST : HS_ROUGH;
						dir_q <= right_first ? ~use_right : rough_dir;
					end
					HS_FIRST: if (first_hit) begin
						span_start_q <= position_i;
						dir_q <= use_right;
						hs_q <= HS_ROUGH;
					end
					HS_ROUGH: if (target_hit) begin
						dir_q <= ~dir_q;
						hs_q <= HS_BACKOFF;
					end else if (far_stop && !ignore_ends) begin
						dir_q <= ~dir_q;
					end
					HS_BACKOFF: if (!target_hit) begin
						// Turn back for the fine pass; a switch that stays active
						// beyond its edge never releases on its far side
						dir_q <= ~dir_q;
						hs_q <= HS_FINE;
					end
					HS_FINE: if (target_hit) begin
						pre_zero_position_q <= position_i;
						if (right_first) begin
							end_switch_span_q <= position_i - span_start_q;
						end
						zero_q <= 1'b1;
						hs_q <= HS_ZERO;
					end
					HS_ZERO: begin
						moving_q <= 1'b0;
						hs_q <= HS_IDLE;
					end
					default: hs_q <= HS_IDLE;
				endcase
			end
		end
	end

	// Encoder null handling and freewheel timer
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			null_prev_q <= 1'b0;
			null_armed_q <= 1'b0;
			enc_clr_q <= 1'b0;
			fw_tick_q <= 32'h0;
			fw_units_q <= 16'h0;
			powered_q <= 1'b1;
		end else if (enable_i) begin
			null_prev_q <= null_act;
			enc_clr_q <= null_clear;
			// Single-shot arms on any write of the control word
			if (wr && idx == axis_setup_pkg::IDX_ENCODER_NULL_CONTROL) begin
				null_armed_q <= 1'b1;
			end else if (null_clear) begin
				null_armed_q <= 1'b0;
			end
			fw_tick_q <= (!standstill || fw_tick) ? 32'h0 : fw_tick_q + 32'h1;
			if (!standstill) begin
				fw_units_q <= 16'h0;
			end else if (fw_tick && fw_units_q != 16'hFFFF) begin
				fw_units_q <= fw_units_q + 16'h1;
			end
			powered_q <= !(standstill && fw_expired);
		end
	end

	// Drive outputs registered
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			drive_q <= '0;
			busy_q <= 1'b0;
		end else if (enable_i) begin
			busy_q <= hs_q != HS_IDLE; // Lines up with drive_o.run in homing; a move command raises run alone
			drive_q <= '{run: moving_q, dir_positive: dir_q,
				speed: (hs_q == HS_IDLE) ? 11'h000 : spd_sel,
				current: cur_sel, power_on: powered_q};
		end
	end

	assign rdata_o = rdata_q;
	assign drive_o = drive_q;
	assign position_zero_o = zero_q;
	assign encoder_clear_o = enc_clr_q;
	assign random_off_time_o = random_off_time_select_q;
	assign homing_busy_o = busy_q;

	// Assertions
	AST_READ_CLEARS: assert property (@(posedge clock_i) disable iff (!resetn_i)
		enable_i && rd && idx == axis_setup_pkg::IDX_STICKY_ERROR_FLAGS && !stall_evt && !dev_evt
		|=> sticky_error_flags_q == 2'b00) else $error("error flags not cleared on read");
	AST_STALL_SET: assert property (@(posedge clock_i) disable iff (!resetn_i)
		enable_i && stall_evt |=> sticky_error_flags_q[0] && !moving_q)
		else $error("stall did not stop or flag");
	AST_DEV_SET: assert property (@(posedge clock_i) disable iff (!resetn_i)
		enable_i && dev_evt |=> sticky_error_flags_q[1]) else $error("deviation not flagged");
	AST_CAPTURE: assert property (@(posedge clock_i) disable iff (!resetn_i)
		$rose(zero_q) |-> pre_zero_position_q == $past(position_i))
		else $error("pre-zero position not captured");
	AST_BOOST: assert property (@(posedge clock_i) disable iff (!resetn_i)
		enable_i && ramping_i && ramp_boost_current_q == 8'h00 ##1 enable_i
		|-> drive_q.current == $past(run_current_q)) else $error("boost zero not run current");
	AST_FREEWHEEL_OFF: assert property (@(posedge clock_i) disable iff (!resetn_i)
		freewheel_delay_q == 16'h0000 && $past(freewheel_delay_q) == 16'h0000 |-> powered_q)
		else $error("power cut with zero delay");
	AST_NULL_CLEAR: assert property (@(posedge clock_i) disable iff (!resetn_i)
		$past(enable_i) && encoder_clear_o |->
		$past(encoder_null_control_q[axis_setup_pkg::NULL_CLEAR_EN_BIT]) && $past(null_edge))
		else $error("encoder clear without enable");
	AST_OFF_TIME: assert property (@(posedge clock_i) disable iff (!resetn_i)
		enable_i && wr && idx == axis_setup_pkg::IDX_RANDOM_OFF_TIME
		|=> random_off_time_o == $past(wdata_i[0])) else $error("off-time select not stored");
	AST_FINE_SPEED: assert property (@(posedge clock_i) disable iff (!resetn_i)
		enable_i && hs_q == HS_FINE ##1 enable_i |-> drive_q.speed == $past(fine_speed_q))
		else $error("fine speed not used");
	COV_HOMING_DONE: cover property (@(posedge clock_i) $rose(zero_q));
	COV_STALL: cover property (@(posedge clock_i) stall_evt);
	COV_POWER_CUT: cover property (@(posedge clock_i) $fell(powered_q));
endmodule : axis_setup

// >>> src/axis_setup_pkg.sv
// Package for the stepper axis setup and homing block.
// Assumes one 100 MHz system clock and a plain strobe-based register port.
package axis_setup_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SLOW_RUN_CURRENT = 8'hB7;
	localparam logic [7:0] IDX_RANDOM_OFF_TIME = 8'hB8;
	localparam logic [7:0] IDX_HOMING_MODE = 8'hC1;
	localparam logic [7:0] IDX_ROUGH_SPEED = 8'hC2;
	localparam logic [7:0] IDX_FINE_SPEED = 8'hC3;
	localparam logic [7:0] IDX_END_SWITCH_SPAN = 8'hC4;
	localparam logic [7:0] IDX_PRE_ZERO_POSITION = 8'hC5;
	localparam logic [7:0] IDX_RAMP_BOOST_CURRENT = 8'hC8;
	localparam logic [7:0] IDX_ENCODER_NULL_CONTROL = 8'hC9;
	localparam logic [7:0] IDX_FREEWHEEL_DELAY = 8'hCC;
	localparam logic [7:0] IDX_LOAD_MEASUREMENT = 8'hCE;
	localparam logic [7:0] IDX_STICKY_ERROR_FLAGS = 8'hCF;
	// Extra registers for settings the rules need but the map lacks
	localparam logic [7:0] IDX_RUN_CURRENT = 8'hD0;
	localparam logic [7:0] IDX_SLOW_THRESHOLD = 8'hD1;
	localparam logic [7:0] IDX_STALL_SPEED = 8'hD2;
	localparam logic [7:0] IDX_MAX_DEVIATION = 8'hD3;
	localparam logic [7:0] IDX_COMMAND = 8'hD4;
	localparam logic [7:0] IDX_STATUS = 8'hD5;

	// Field positions
	localparam int MODE_INVERT_HOME_BIT = 7;
	localparam int MODE_RIGHT_REF_BIT = 6;
	localparam int NULL_CLEAR_EN_BIT = 2;
	localparam int NULL_REPEAT_BIT = 3;
	localparam int NULL_POLARITY_BIT = 4;
	localparam int ERR_STALL_BIT = 0;
	localparam int ERR_DEVIATION_BIT = 1;
	localparam int CMD_HOMING_BIT = 0;
	localparam int CMD_MOVE_BIT = 1;
	localparam int CMD_STOP_BIT = 2;

	// Reset values
	localparam logic [7:0] RST_CURRENT = 8'h00;
	localparam logic [7:0] RST_HOMING_MODE = 8'h01;
	localparam logic [10:0] RST_SPEED = 11'h000;
	localparam logic [15:0] RST_FREEWHEEL = 16'h0000;
	localparam logic [4:0] RST_NULL_CONTROL = 5'h00;

	// Full-scale current setting
	localparam logic [7:0] CURRENT_FULL = 8'hFF;

	// Freewheel delay tick: 10 ms per unit
	localparam int FREEWHEEL_UNIT_NS = 10000000;
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int FREEWHEEL_TICK_CYCLES = FREEWHEEL_UNIT_NS / CLOCK_PERIOD_NS;

	// Motion request towards the motion core
	typedef struct packed {
		logic run;
		logic dir_positive;
		logic [10:0] speed;
		logic [7:0] current;
		logic power_on;
	} motor_drive_t;

	// Switch inputs as seen by the homing sequencer
	typedef struct packed {
		logic left_stop;
		logic right_stop;
		logic home;
	} switch_set_t;

endpackage : axis_setup_pkg

// >>> testbench/axis_far_side.sv
// Far side of the axis block: motor, end and home switches, encoder.
// Assumes the drive request and the clear pulses arrive on clock_i.
`timescale 1ns/100ps
module axis_far_side #(
	parameter int LEFT_END = -1000,
	parameter int RIGHT_END = 1000
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire axis_setup_pkg::motor_drive_t drive_i,
	input wire logic position_zero_i,
	input wire logic encoder_clear_i,
	output logic [31:0] position_o,
	output logic [10:0] velocity_o,
	output logic ramping_o,
	output logic [31:0] encoder_o,
	output logic null_channel_o,
	output axis_setup_pkg::switch_set_t switches_o
);
	logic signed [31:0] phys_q;
	logic signed [31:0] zero_ref_q;
	logic signed [31:0] enc_ref_q;
	logic [3:0] ramp_q;

	// One microstep a cycle while running; zero and clear rebase the counters
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phys_q <= 32'sh0;
			zero_ref_q <= 32'sh0;
			enc_ref_q <= 32'sh0;
			ramp_q <= 4'h0;
		end else begin
			if (drive_i.run)
				phys_q <= drive_i.dir_positive ? phys_q + 32'sh1 : phys_q - 32'sh1;
			ramp_q <= !drive_i.run ? 4'h0 : (ramp_q == 4'hF ? ramp_q : ramp_q + 4'h1);
			if (position_zero_i)
				zero_ref_q <= phys_q;
			if (encoder_clear_i)
				enc_ref_q <= phys_q;
		end
	end

	// Home flag repeats every 256 steps so a home search always ends
	assign position_o = phys_q - zero_ref_q;
	assign encoder_o = phys_q - enc_ref_q;
	assign velocity_o = drive_i.run ? drive_i.speed : 11'h000;
	assign ramping_o = drive_i.run && (ramp_q < 4'h8); // Eight cycles of ramp after a start
	assign null_channel_o = (phys_q[3:0] == 4'h0);
	assign switches_o = '{left_stop: (phys_q <= LEFT_END), right_stop: (phys_q >= RIGHT_END),
		home: (phys_q[7:0] >= 8'h32) && (phys_q[7:0] <= 8'h3C)};
endmodule : axis_far_side

// >>> testbench/test_stepper_homing_and_axis_setup.sv
// Self-checking bench for the axis setup and homing block.
// Assumes the far-side model and a shortened freewheel tick.
`timescale 1ns/100ps
module test_stepper_homing_and_axis_setup;
	typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] ex;} row_t;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic enable_i = 1'b1;
	logic [9:0] addr_i = 10'h000;
	logic [31:0] wdata_i = 32'h00000000;
	logic write_i = 1'b0;
	logic read_i = 1'b0;
	logic [9:0] load_i = 10'h3FF;
	logic [31:0] rdata_o, position_i, encoder_i, rd, last_pos, first_pos;
	logic [10:0] velocity_i, last_speed;
	logic ramping_i, null_channel_i, position_zero_o, encoder_clear_o;
	logic random_off_time_o, homing_busy_o, got_first;
	axis_setup_pkg::switch_set_t switches_i;
	axis_setup_pkg::motor_drive_t drive_o;
	int n_fail = 0;
	int n_tests = 0;
	int count;
	row_t rows [10] = '{
		'{8'hB7, 32'hFFFFFFA5, 32'h000000A5}, '{8'hB8, 32'h00000003, 32'h00000001},
		'{8'hC2, 32'h0000F0C8, 32'h000000C8}, '{8'hC3, 32'h00000032, 32'h00000032},
		'{8'hC8, 32'h000001FF, 32'h000000FF}, '{8'hC9, 32'h000000FF, 32'h0000001F},
		'{8'hCC, 32'h00010000, 32'h00000000}, '{8'hC1, 32'h00000041, 32'h00000041},
		'{8'hCE, 32'h00000000, 32'h000003FF}, '{8'h10, 32'h00000055, 32'h00000000}};
	logic [7:0] modes [10] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h04,
		8'h41, 8'h05, 8'h08, 8'h07, 8'h85};
	logic dirs [10] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

	axis_setup #(.FREEWHEEL_TICK(4)) u_axis_setup (.clock_i(clock_i), .resetn_i(resetn_i),
		.enable_i(enable_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
		.read_i(read_i), .rdata_o(rdata_o), .position_i(position_i), .velocity_i(velocity_i),
		.ramping_i(ramping_i), .load_i(load_i), .encoder_i(encoder_i),
		.null_channel_i(null_channel_i), .switches_i(switches_i), .drive_o(drive_o),
		.position_zero_o(position_zero_o), .encoder_clear_o(encoder_clear_o),
		.random_off_time_o(random_off_time_o), .homing_busy_o(homing_busy_o));
	axis_far_side u_axis_far_side (.clock_i(clock_i), .resetn_i(resetn_i), .drive_i(drive_o),
		.position_zero_i(position_zero_o), .encoder_clear_i(encoder_clear_o),
		.position_o(position_i), .velocity_o(velocity_i), .ramping_o(ramping_i),
		.encoder_o(encoder_i), .null_channel_o(null_channel_i), .switches_o(switches_i));

	// 100 MHz clock
	always #5 clock_i = ~clock_i;

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check_word

	task automatic check_bit(input string what, input logic exp, input logic got);
		check_word(what, {31'h0, exp}, {31'h0, got});
	endtask : check_bit

	task automatic wr(input logic [7:0] idx, input logic [31:0] data);
		@(posedge clock_i);
		addr_i <= {idx, 2'b00};
		wdata_i <= data;
		write_i <= 1'b1;
		@(posedge clock_i);
		write_i <= 1'b0;
	endtask : wr

	task automatic rd_reg(input logic [7:0] idx, output logic [31:0] data);
		@(posedge clock_i);
		addr_i <= {idx, 2'b00};
		read_i <= 1'b1;
		@(posedge clock_i);
		read_i <= 1'b0;
		#1 data = rdata_o;
	endtask : rd_reg

	// Bounded wait for the sequencer to reach the given busy level
	task automatic wait_busy(input logic level);
		count = 0;
		while (homing_busy_o !== level && count < 8000) begin
			@(negedge clock_i);
			count++;
		end
		check_bit("busy level", level, homing_busy_o);
	endtask : wait_busy

	task automatic start_run;
		wr(axis_setup_pkg::IDX_COMMAND, 32'h1 << axis_setup_pkg::CMD_HOMING_BIT);
		count = 0;
		while (drive_o.run !== 1'b1 && count < 20) begin
			@(negedge clock_i);
			count++;
		end
	endtask : start_run

	task automatic stop_run;
		wr(axis_setup_pkg::IDX_COMMAND, 32'h1 << axis_setup_pkg::CMD_STOP_BIT);
		wait_busy(1'b0);
	endtask : stop_run

	// Current in mid-ramp and at cruise, cruise being at the rough speed
	task automatic probe_current(input logic [7:0] at_ramp, input logic [7:0] at_cruise);
		start_run;
		repeat (4) @(negedge clock_i);
		check_word("ramp current", {24'h0, at_ramp}, {24'h0, drive_o.current});
		repeat (16) @(negedge clock_i);
		check_word("cruise current", {24'h0, at_cruise}, {24'h0, drive_o.current});
		stop_run;
	endtask : probe_current

	// Clear pulses while moving: 0 none, 1 exactly one, 3 three or more
	task automatic count_clears(input logic [4:0] ctrl, input logic [31:0] exp);
		int seen;
		seen = 0;
		wr(axis_setup_pkg::IDX_ENCODER_NULL_CONTROL, {27'h0, ctrl});
		start_run;
		repeat (80) begin
			@(negedge clock_i);
			if (encoder_clear_o === 1'b1)
				seen++;
		end
		check_word("encoder clears", exp, (seen >= 3) ? 32'd3 : 32'(seen));
		stop_run;
	endtask : count_clears

	task automatic stall_run;
		start_run;
		@(posedge clock_i);
		load_i <= 10'h000;
		wait_busy(1'b0);
		check_bit("run after stall", 1'b0, drive_o.run);
		@(posedge clock_i);
		load_i <= 10'h3FF;
	endtask : stall_run

	task automatic stall_and_read(input logic [31:0] flags);
		stall_run;
		rd_reg(axis_setup_pkg::IDX_STICKY_ERROR_FLAGS, rd);
		check_word("stall flag", flags, rd);
	endtask : stall_and_read

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	// Watchdog sized well above the longest homing sequence
	initial begin
		#900000;
		n_fail++;
		complete_run;
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge clock_i);
		check_word("reset rdata", 32'h0, rdata_o);
		check_word("reset drive", 32'h0, {10'h0, drive_o});
		check_bit("reset busy", 1'b0, homing_busy_o);
		resetn_i <= 1'b1;
		rd_reg(axis_setup_pkg::IDX_HOMING_MODE, rd);
		check_word("homing mode reset", {24'h0, axis_setup_pkg::RST_HOMING_MODE}, rd);
		// Fine speed 0x32 kept below rough speed 0xC8
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			rd_reg(rows[i].idx, rd);
			check_word("register readback", rows[i].ex, rd);
		end
		check_bit("random off time", 1'b1, random_off_time_o);
		wr(axis_setup_pkg::IDX_RANDOM_OFF_TIME, 32'h0);
		repeat (2) @(negedge clock_i);
		check_bit("fixed off time", 1'b0, random_off_time_o);
		@(posedge clock_i);
		enable_i <= 1'b0;
		wr(axis_setup_pkg::IDX_SLOW_RUN_CURRENT, 32'h11);
		enable_i <= 1'b1;
		rd_reg(axis_setup_pkg::IDX_SLOW_RUN_CURRENT, rd);
		check_word("write while disabled", 32'hA5, rd);
		wr(axis_setup_pkg::IDX_HOMING_MODE, 32'h1);
		count_clears(5'h14, 32'd1);
		count_clears(5'h1C, 32'd3);
		count_clears(5'h0C, 32'd3);
		count_clears(5'h18, 32'd0);
		wr(axis_setup_pkg::IDX_RUN_CURRENT, 32'h60);
		wr(axis_setup_pkg::IDX_SLOW_THRESHOLD, 32'h7FF);
		probe_current(8'hFF, 8'hA5);
		wr(axis_setup_pkg::IDX_SLOW_THRESHOLD, 32'h0);
		probe_current(8'hFF, 8'h60);
		wr(axis_setup_pkg::IDX_RAMP_BOOST_CURRENT, 32'h0);
		probe_current(8'h60, 8'h60);
		wr(axis_setup_pkg::IDX_STALL_SPEED, 32'h0);
		stall_and_read(32'h1 << axis_setup_pkg::ERR_STALL_BIT);
		rd_reg(axis_setup_pkg::IDX_STICKY_ERROR_FLAGS, rd);
		check_word("flags after read", 32'h0, rd);
		stall_and_read(32'h1 << axis_setup_pkg::ERR_STALL_BIT);
		// Leave a stall flag standing so that only the move command can clear it
		stall_run;
		wr(axis_setup_pkg::IDX_COMMAND, 32'h1 << axis_setup_pkg::CMD_MOVE_BIT);
		stop_run;
		rd_reg(axis_setup_pkg::IDX_STICKY_ERROR_FLAGS, rd);
		check_word("flags after command", 32'h0, rd);
		wr(axis_setup_pkg::IDX_MAX_DEVIATION, 32'h5);
		start_run;
		wait_busy(1'b0);
		rd_reg(axis_setup_pkg::IDX_STICKY_ERROR_FLAGS, rd);
		check_word("deviation flag", 32'h1 << axis_setup_pkg::ERR_DEVIATION_BIT, rd);
		wr(axis_setup_pkg::IDX_MAX_DEVIATION, 32'h0);
		// Every homing mode and both modifiers, each run to its zeroing pulse
		foreach (modes[i]) begin
			wr(axis_setup_pkg::IDX_HOMING_MODE, {24'h0, modes[i]});
			start_run;
			check_bit("first direction", dirs[i], drive_o.dir_positive);
			check_word("rough speed", 32'hC8, {21'h0, drive_o.speed});
			got_first = 1'b0;
			count = 0;
			while (position_zero_o !== 1'b1 && count < 8000) begin
				last_pos = position_i;
				last_speed = drive_o.speed;
				if (switches_i.right_stop === 1'b1 && !got_first) begin
					first_pos = position_i;
					got_first = 1'b1;
				end
				@(negedge clock_i);
				count++;
			end
			check_bit("zero pulse", 1'b1, position_zero_o);
			check_word("fine speed", 32'h32, {21'h0, last_speed});
			@(negedge clock_i);
			check_bit("zero pulse width", 1'b0, position_zero_o);
			rd_reg(axis_setup_pkg::IDX_PRE_ZERO_POSITION, rd);
			check_word("pre-zero position", last_pos, rd);
			if (modes[i] == 8'h02) begin
				rd_reg(axis_setup_pkg::IDX_END_SWITCH_SPAN, rd);
				check_word("end switch span", last_pos - first_pos, rd);
			end
			wait_busy(1'b0);
		end
		wr(axis_setup_pkg::IDX_FREEWHEEL_DELAY, 32'h0);
		repeat (40) @(negedge clock_i);
		check_bit("power kept", 1'b1, drive_o.power_on);
		wr(axis_setup_pkg::IDX_FREEWHEEL_DELAY, 32'h3);
		repeat (40) @(negedge clock_i);
		check_bit("power cut", 1'b0, drive_o.power_on);
		complete_run;
	end
endmodule : test_stepper_homing_and_axis_setup
